/* shared/pwr_pkg.sv */
// Purpose: Shared constants and carriers for the core power controller
// Assumes: One 50 MHz clock, registers on a plain strobe port
// Notes:   Offsets are byte addresses of aligned 32-bit words
package pwr_pkg;
  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int NBRANCH = 8;
  localparam int LVL_W   = 4;
  localparam int AW      = 4;
  localparam int DW      = 32;

  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFF_CTRL   = 4'h0;
  localparam logic [AW-1:0] OFF_STATUS = 4'h4;
  localparam int CTRL_GLOBAL_BIT = 0;
  localparam int CTRL_FUNC_BIT   = 1;
  localparam int ST_STATE_LSB    = 0;
  localparam int ST_LEVEL_LSB    = 4;
  localparam int ST_FREEZE_BIT   = 8;
  localparam int ST_SLEEP_BIT    = 9;
  localparam logic CTRL_GLOBAL_RST = 1'b1;
  localparam logic CTRL_FUNC_RST   = 1'b1;
  localparam logic [LVL_W-1:0] LEVEL_RST = 4'h0;

  // ----------------------------------------------------------------
  // Sleep sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_DRAIN = 2'b01,
    ST_SLEEP = 2'b10
  } pstate_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               wait_for_interrupt_instruction_done;  // Wait instruction completes
    logic [LVL_W-1:0]   wait_for_interrupt_instruction_level; // Level encoded in it
    logic [2:0]         mem_busy;    // Instr, data, local port busy
    logic [LVL_W-1:0]   irq_level;   // Highest unmasked pending level
    logic               fill_active; // Cache line fill in progress
    logic               lsu_idle;    // Load/store units idle
    logic [2:0]         mem_req;     // Core wants instr, data, local mem
    logic               inb_req;     // Inbound bus request active
    logic [2:0]         inb_local;   // Inbound to instr, data, local mem
    logic [NBRANCH-1:0] func_act;    // Local activity per branch
  } core_in_s;

  typedef struct packed {
    logic core;
    logic bus;
    logic inbound;
    logic fill;
    logic lsu;
  } gclk_en_s;

  typedef struct packed {
    logic imem;
    logic dmem;
    logic lmem;
  } mem_en_s;
endpackage

/* design/sync2.sv */
// Purpose: Two-stage synchroniser for one asynchronous level
// Assumes: Input comes from outside the clock domain
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
module sync2 (
  input  wire logic clock,   // Core clock
  input  wire logic reset,   // Async reset, active high
  input  wire logic d,       // Asynchronous level
  output logic      q        // Synchronised level
);
  typedef struct packed {
    logic meta;
    logic sync;
  } sync_s;

  sync_s st_r;
  sync_s st_nxt;

  // Shift chain; the first stage feeds only the second
  always_comb begin
    st_nxt.meta = d;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.sync;
endmodule

/* design/branch_gates.sv */
// Purpose: Registered clock enables for the small functional branches
// Assumes: core_en_nxt is the next value of the core branch enable
// Notes:   Outputs come from flops, aligned with the core enable
`timescale 1ns/1ps
module branch_gates
  import pwr_pkg::*;
(
  input  wire logic               clock,       // Core clock
  input  wire logic               reset,       // Async reset, active high
  input  wire logic               core_en_nxt, // Next core enable
  input  wire logic               func_en,     // Functional gating selected
  input  wire logic [NBRANCH-1:0] act,         // Local activity
  output logic      [NBRANCH-1:0] en           // Branch enables
);
  typedef struct packed {
    logic [NBRANCH-1:0] en;
  } br_s;

  br_s st_r;
  br_s st_nxt;

  // Each branch runs with the core and, if selected, its own activity
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < NBRANCH; i++) begin
      st_nxt.en[i] = core_en_nxt && (!func_en || act[i]);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r <= '{en: '1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign en = st_r.en;

  // Idle branch with functional gating must be off next cycle
  idle_branch_a: assert property (@(posedge clock) disable iff (reset)
    (func_en && act == '0) |=> (en == '0))
    else $error("idle branch clock left running");
endmodule

/* design/pwr_ctl.sv */
// Purpose: Sleep, stall and clock-gating control of the processor core
// Assumes: Core-side inputs are on CLOCK; FREEZE is an external pin
// Notes:   Enables drive external gating cells; memory requests are early
//
// Function
// - Inactive register groups get their clock enable removed.
// - Instruction and data memories are enabled only when needed.
// - Global and functional gating are separately selectable.
// - Global gating also gates fill and load/store logic when idle.
// - Functional gating splits clocks into branches with local enables.
// - Wait instruction and sleep output exist only with interrupts.
// - Completed wait instruction loads the current interrupt level.
// - After loading the level, wait until memory interfaces are idle.
// - Then raise sleep output and suspend until an unmasked interrupt.
// - With global gating, most clocks stop while sleeping.
// - Without global gating, operations suspend but clocks run.
// - Inbound bus requests are serviced during sleep.
// - Inbound logic clock has its own gating conditions.
// - Freeze input stalls the pipeline for as long as it is high.
// - While frozen outside sleep with global gating, bus interface clock keeps running.
// - While frozen with global gating, fill logic is clocked only during a fill.
// - While frozen, memory enables drop except for fills and inbound.
`timescale 1ns/1ps
module pwr_ctl
  import pwr_pkg::*;
#(
  parameter bit HAS_INTERRUPTS = 1'b1
) (
  input  wire logic               CLOCK,       // 50 MHz core clock
  input  wire logic               RESET,       // Async reset, active high
  input  wire logic [AW-1:0]      ADDR,        // Register byte address
  input  wire logic [DW-1:0]      WDATA,       // Write data
  input  wire logic               WR,          // Write strobe
  input  wire logic               RD,          // Read strobe
  output logic      [DW-1:0]      RDATA,       // Read data, cycle after RD
  input  wire core_in_s           CORE_IN,     // Core status group
  input  wire logic               FREEZE,      // Pipeline freeze pin
  output logic                    SLEEP_IND,   // Sleep indicator
  output logic                    PIPE_STALL,  // Pipeline hold
  output logic      [LVL_W-1:0]   INTLEVEL,    // Current interrupt level
  output gclk_en_s                CLK_EN,      // Global clock enables
  output logic      [NBRANCH-1:0] BRANCH_EN,   // Functional branch enables
  output mem_en_s                 MEM_EN       // Local memory enables
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pstate_e          state;
    logic [LVL_W-1:0] level;
    logic             global_en;
    logic             func_en;
    logic             sleep_ind;
    logic             stall;
    gclk_en_s         clk_en;
    mem_en_s          mem_en;
    logic [DW-1:0]    rdata;
  } pctl_s;

  pctl_s st_r;
  pctl_s st_nxt;
  logic  freeze_s;

  // Freeze arrives from system logic on its own timing
  sync2 u_freeze_sync (
    .clock (CLOCK),
    .reset (RESET),
    .d     (FREEZE),
    .q     (freeze_s)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Register read view, shared by the read mux
  function automatic logic [DW-1:0] read_word(input logic [AW-1:0] a,
                                              input pctl_s s,
                                              input logic frz);
    logic [DW-1:0] w;
    w = '0;
    if (a == OFF_CTRL) begin
      w[CTRL_GLOBAL_BIT] = s.global_en;
      w[CTRL_FUNC_BIT]   = s.func_en;
    end else if (a == OFF_STATUS) begin
      w[ST_STATE_LSB +: 2]     = s.state;
      w[ST_LEVEL_LSB +: LVL_W] = s.level;
      w[ST_FREEZE_BIT]         = frz;
      w[ST_SLEEP_BIT]          = s.sleep_ind;
    end
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic mem_idle;
  logic wake;
  logic sleeping_n;
  logic active_n;
  logic gate_on;

  assign mem_idle = (CORE_IN.mem_busy == '0);
  assign wake     = (CORE_IN.irq_level > st_r.level);

  // Sequencer, register port and enables in one pass
  always_comb begin
    st_nxt     = st_r;
    sleeping_n = 1'b0;
    active_n   = 1'b0;
    gate_on    = st_r.global_en;

    // Register writes steer the gating options
    if (WR && ADDR == OFF_CTRL) begin
      st_nxt.global_en = WDATA[CTRL_GLOBAL_BIT];
      st_nxt.func_en   = WDATA[CTRL_FUNC_BIT];
    end
    st_nxt.rdata = RD ? read_word(ADDR, st_r, freeze_s) : '0;

    // Wait sequence
    unique case (st_r.state)
      ST_RUN: begin
        if (HAS_INTERRUPTS && CORE_IN.wait_for_interrupt_instruction_done) begin
          st_nxt.level = CORE_IN.wait_for_interrupt_instruction_level;
          st_nxt.state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        // Sleep only once every memory interface is quiet
        if (mem_idle) begin
          st_nxt.state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          st_nxt.state = ST_RUN;
        end
      end
      default: begin
        st_nxt.state = ST_RUN;
      end
    endcase

    sleeping_n       = (st_nxt.state == ST_SLEEP);
    st_nxt.sleep_ind = sleeping_n;
    // Suspended while draining, sleeping or frozen; no safety check
    st_nxt.stall = (st_nxt.state != ST_RUN) || freeze_s;
    active_n     = !st_nxt.stall;

    // Most clocks stop in sleep or freeze, only with global gating
    st_nxt.clk_en.core = !(gate_on && (sleeping_n || freeze_s));
    // Bus interface stays clocked while frozen outside sleep and for inbound traffic
    st_nxt.clk_en.bus = !(gate_on && sleeping_n && !CORE_IN.inb_req);
    // Inbound logic follows its own request, not the core state
    st_nxt.clk_en.inbound = !gate_on || CORE_IN.inb_req;
    // With global gating, fill logic runs only while a fill is in flight, frozen or not
    st_nxt.clk_en.fill = !gate_on || CORE_IN.fill_active;
    st_nxt.clk_en.lsu  = !gate_on || (active_n && !CORE_IN.lsu_idle);

    // Memories on for core use, fills and inbound hits only
    st_nxt.mem_en.imem = (active_n && CORE_IN.mem_req[0]) || CORE_IN.fill_active
                         || CORE_IN.inb_local[0];
    st_nxt.mem_en.dmem = (active_n && CORE_IN.mem_req[1]) || CORE_IN.fill_active
                         || CORE_IN.inb_local[1];
    st_nxt.mem_en.lmem = (active_n && CORE_IN.mem_req[2]) || CORE_IN.fill_active
                         || CORE_IN.inb_local[2];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Clocks run and memories rest until the core asks
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      st_r.state     <= ST_RUN;
      st_r.level     <= LEVEL_RST;
      st_r.global_en <= CTRL_GLOBAL_RST;
      st_r.func_en   <= CTRL_FUNC_RST;
      st_r.sleep_ind <= 1'b0;
      st_r.stall     <= 1'b0;
      st_r.clk_en    <= '1;
      st_r.mem_en    <= '0;
      st_r.rdata     <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Branch enables track the next core enable so both switch together
  branch_gates u_branch (
    .clock       (CLOCK),
    .reset       (RESET),
    .core_en_nxt (st_nxt.clk_en.core),
    .func_en     (st_r.func_en),
    .act         (CORE_IN.func_act),
    .en          (BRANCH_EN)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RDATA      = st_r.rdata;
  assign SLEEP_IND  = st_r.sleep_ind;
  assign PIPE_STALL = st_r.stall;
  assign INTLEVEL   = st_r.level;
  assign CLK_EN     = st_r.clk_en;
  assign MEM_EN     = st_r.mem_en;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);

  sequence seq_wait_taken;
    (st_r.state == ST_RUN) && CORE_IN.wait_for_interrupt_instruction_done;
  endsequence

  sequence seq_wake_cause;
    (st_r.state == ST_SLEEP) && (CORE_IN.irq_level > st_r.level);
  endsequence

  // A freeze at the wake edge keeps the core clock off; that is freeze, not sleep
  sequence seq_resumed;
    !SLEEP_IND && (st_r.state == ST_RUN) && (CLK_EN.core || $past(freeze_s));
  endsequence

  level_load_a: assert property (
    (seq_wait_taken and HAS_INTERRUPTS) |=> INTLEVEL == $past(CORE_IN.wait_for_interrupt_instruction_level))
    else $error("interrupt level not loaded by wait");

  no_irq_sleep_a: assert property (
    !HAS_INTERRUPTS |-> !SLEEP_IND && st_r.state == ST_RUN)
    else $error("sleep without interrupts configured");

  drain_hold_a: assert property (
    (st_r.state == ST_DRAIN) && !mem_idle |=> !SLEEP_IND)
    else $error("sleep entered with busy memory");

  sleep_entry_a: assert property (
    $rose(SLEEP_IND) |-> $past(st_r.state) == ST_DRAIN && $past(mem_idle) && PIPE_STALL)
    else $error("sleep raised without idle drain");

  gated_sleep_a: assert property (
    SLEEP_IND && $past(st_r.global_en) |-> !CLK_EN.core && !CLK_EN.lsu)
    else $error("clocks left on in gated sleep");

  ungated_sleep_a: assert property (
    SLEEP_IND && !$past(st_r.global_en) |-> CLK_EN.core && PIPE_STALL)
    else $error("ungated sleep stopped clocks");

  inbound_clk_a: assert property (
    CORE_IN.inb_req |=> CLK_EN.inbound && CLK_EN.bus)
    else $error("inbound clock gated during request");

  freeze_stall_a: assert property (
    freeze_s |=> PIPE_STALL)
    else $error("freeze did not stall pipeline");

  frozen_bus_a: assert property (
    freeze_s && st_r.state == ST_RUN |=> CLK_EN.bus && (!$past(st_r.global_en) || !CLK_EN.core))
    else $error("freeze gating wrong");

  fill_clock_a: assert property (
    CORE_IN.fill_active |=> CLK_EN.fill && MEM_EN.imem && MEM_EN.dmem)
    else $error("fill lost clock or memory");

  frozen_mem_a: assert property (
    freeze_s && !CORE_IN.fill_active && CORE_IN.inb_local == '0 |=> MEM_EN == '0)
    else $error("memory enabled while frozen");

  wake_resume_a: assert property (
    seq_wake_cause |=> seq_resumed)
    else $error("interrupt did not end sleep");
endmodule

/* testbench/sys_ctl_model.sv */
// Purpose: System-side model driving the freeze pin and inbound traffic
// Assumes: Commands come from the bench on the core clock
// Notes:   Slow mode moves the freeze pin three cycles late
`timescale 1ns/1ps
module sys_ctl_model (
  input  wire logic       clock,      // Core clock
  input  wire logic       reset,      // Async reset, active high
  input  wire logic       freeze_cmd, // Bench wants the core frozen
  input  wire logic       slow,       // Answer late
  input  wire logic [2:0] inb_cmd,    // Inbound target: instr, data, local
  output logic            freeze,     // Freeze pin
  output logic            inb_req,    // Inbound request active
  output logic      [2:0] inb_local   // Inbound target lines
);
  logic [2:0] dly_r;

  // Delay line for the late answer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dly_r <= 3'h0;
    end else begin
      dly_r <= {dly_r[1:0], freeze_cmd};
    end
  end

  // No safety check: freezing whenever told is this side's own call
  assign freeze    = slow ? dly_r[2] : freeze_cmd;
  assign inb_local = inb_cmd;
  assign inb_req   = |inb_cmd;
endmodule

/* testbench/test_pwr_ctl.sv */
// Purpose: Self-checking bench for the core power controller
// Assumes: Enables are registered, one edge after their inputs
// Notes:   A second instance without interrupts checks the wait refusal
`timescale 1ns/1ps
module test_pwr_ctl
  import pwr_pkg::*;
;
  typedef struct packed {
    logic [1:0] ctrl;
    logic [2:0] req;
    logic       fill;
    logic [2:0] inb;
    logic [7:0] act;
    logic [2:0] mem;
    logic [7:0] br;
  } row_s;

  logic                CLOCK, RESET, WR, RD, freeze_cmd, slow;
  logic                FREEZE, inb_req, SLEEP_IND, PIPE_STALL, n_sleep, n_stall;
  logic [AW-1:0]       ADDR;
  logic [DW-1:0]       WDATA, RDATA, rdv;
  logic [2:0]          inb_cmd, inb_local;
  logic [LVL_W-1:0]    INTLEVEL;
  logic [NBRANCH-1:0]  BRANCH_EN;
  core_in_s            ci, core_in;
  gclk_en_s            CLK_EN;
  mem_en_s             MEM_EN;
  int                  bad_count, total_checks, n;
  // Request bit 0 is instr, enable MSB is instr
  row_s rows [7] = '{
    '{2'h3, 3'h1, 1'b0, 3'h0, 8'hA5, 3'h4, 8'hA5},
    '{2'h3, 3'h6, 1'b0, 3'h0, 8'h00, 3'h3, 8'h00},
    '{2'h3, 3'h0, 1'b1, 3'h0, 8'h0F, 3'h7, 8'h0F},
    '{2'h3, 3'h0, 1'b0, 3'h2, 8'hF0, 3'h2, 8'hF0},
    '{2'h1, 3'h0, 1'b0, 3'h0, 8'h00, 3'h0, 8'hFF},
    '{2'h0, 3'h5, 1'b0, 3'h0, 8'h3C, 3'h5, 8'hFF},
    '{2'h2, 3'h0, 1'b0, 3'h0, 8'h3C, 3'h0, 8'h3C}};

  // Inbound fields come from the system model
  always_comb begin
    core_in           = ci;
    core_in.inb_req   = inb_req;
    core_in.inb_local = inb_local;
  end

  pwr_ctl #(.HAS_INTERRUPTS(1'b1)) u_dut (
    .CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CORE_IN(core_in), .FREEZE(FREEZE), .SLEEP_IND(SLEEP_IND),
    .PIPE_STALL(PIPE_STALL), .INTLEVEL(INTLEVEL), .CLK_EN(CLK_EN),
    .BRANCH_EN(BRANCH_EN), .MEM_EN(MEM_EN));
  pwr_ctl #(.HAS_INTERRUPTS(1'b0)) u_noirq (
    .CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(), .CORE_IN(core_in), .FREEZE(FREEZE), .SLEEP_IND(n_sleep),
    .PIPE_STALL(n_stall), .INTLEVEL(), .CLK_EN(), .BRANCH_EN(), .MEM_EN());
  sys_ctl_model u_sys (
    .clock(CLOCK), .reset(RESET), .freeze_cmd(freeze_cmd), .slow(slow),
    .inb_cmd(inb_cmd), .freeze(FREEZE), .inb_req(inb_req), .inb_local(inb_local));

  // ----------------------------------------------------------------
  // Clock, helpers and verdict
  // ----------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge CLOCK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a);
    @(posedge CLOCK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 rdv = RDATA;
  endtask

  // Bounded wait; the synchroniser makes the exact edge uncertain
  task automatic wait_stall(input logic lvl);
    n = 0;
    while (PIPE_STALL !== lvl && n < 8) begin
      @(posedge CLOCK);
      #1 n++;
    end
  endtask

  task automatic stop_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge CLOCK);
    bad_count++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {RESET, WR, RD, ADDR, WDATA, freeze_cmd, slow, inb_cmd} = '0;
    RESET = 1'b1;
    ci = '0;
    ci.lsu_idle = 1'b1;
    bad_count = 0;
    total_checks = 0;
    repeat (5) @(posedge CLOCK);
    #1;
    chk(CLK_EN, 5'h1F);
    chk(BRANCH_EN, 8'hFF);
    chk({SLEEP_IND, PIPE_STALL, MEM_EN, RDATA}, 32'h0);
    @(posedge CLOCK);
    RESET <= 1'b0;
    rd(OFF_CTRL);
    chk(rdv, 32'h3);
    foreach (rows[i]) begin
      wr(OFF_CTRL, {30'h0, rows[i].ctrl});
      @(posedge CLOCK);
      ci.mem_req     <= rows[i].req;
      ci.fill_active <= rows[i].fill;
      ci.func_act    <= rows[i].act;
      inb_cmd        <= rows[i].inb;
      @(posedge CLOCK);
      #1;
      chk(MEM_EN, rows[i].mem);
      chk(BRANCH_EN, rows[i].br);
      // Logical not: a bitwise one would widen to the task's 32-bit argument
      chk(CLK_EN.fill, !rows[i].ctrl[0] || rows[i].fill);
      chk(CLK_EN.lsu, !rows[i].ctrl[0]);
    end
    // Read-only and unmapped places leave state alone
    wr(OFF_STATUS, 32'hFFFFFFFF);
    wr(4'h8, 32'h0);
    rd(4'h8);
    chk(rdv, 32'h0);
    rd(OFF_STATUS);
    chk(rdv, 32'h0);
    rd(OFF_CTRL);
    chk(rdv, 32'h2);
    // Wait with a busy data port, then sleep and wake
    wr(OFF_CTRL, 32'h3);
    @(posedge CLOCK);
    ci.mem_req     <= 3'h0;
    ci.wait_for_interrupt_instruction_done  <= 1'b1;
    ci.wait_for_interrupt_instruction_level <= 4'h3;
    ci.mem_busy    <= 3'h2;
    @(posedge CLOCK);
    ci.wait_for_interrupt_instruction_done <= 1'b0;
    #1;
    chk(INTLEVEL, 32'h3);
    chk(PIPE_STALL, 1'b1);
    @(posedge CLOCK);
    ci.mem_busy <= 3'h0;
    #1 chk(SLEEP_IND, 1'b0);
    @(posedge CLOCK);
    inb_cmd <= 3'h4;
    #1 chk(SLEEP_IND, 1'b1);
    chk(CLK_EN.bus, 1'b0);
    chk({n_sleep, n_stall}, 32'h0);
    @(posedge CLOCK);
    ci.irq_level <= 4'h3;
    #1;
    chk({CLK_EN.core, CLK_EN.lsu, BRANCH_EN}, 32'h0);
    chk({CLK_EN.inbound, CLK_EN.bus}, 2'h3);
    chk(MEM_EN, 3'h1);
    rd(OFF_STATUS);
    chk(rdv, 32'h232);
    @(posedge CLOCK);
    ci.irq_level <= 4'h4;
    inb_cmd      <= 3'h0;
    #1 chk(SLEEP_IND, 1'b1);
    @(posedge CLOCK);
    #1 chk({SLEEP_IND, PIPE_STALL, CLK_EN.core}, 32'h1);
    // Sleep without global gating keeps clocks on
    wr(OFF_CTRL, 32'h2);
    @(posedge CLOCK);
    ci.irq_level   <= 4'h0;
    ci.wait_for_interrupt_instruction_done  <= 1'b1;
    ci.wait_for_interrupt_instruction_level <= 4'h5;
    @(posedge CLOCK);
    ci.wait_for_interrupt_instruction_done <= 1'b0;
    repeat (2) @(posedge CLOCK);
    #1 chk({SLEEP_IND, PIPE_STALL, CLK_EN}, 32'h7F);
    @(posedge CLOCK);
    ci.irq_level <= 4'h6;
    @(posedge CLOCK);
    #1 chk(SLEEP_IND, 1'b0);
    // Freeze with memory requests pending, released late
    wr(OFF_CTRL, 32'h3);
    @(posedge CLOCK);
    ci.irq_level <= 4'h0;
    ci.mem_req   <= 3'h7;
    freeze_cmd   <= 1'b1;
    wait_stall(1'b1);
    chk(PIPE_STALL, 1'b1);
    @(posedge CLOCK);
    #1 chk({CLK_EN.core, CLK_EN.bus}, 32'h1);
    chk({MEM_EN, CLK_EN.fill}, 32'h0);
    @(posedge CLOCK);
    inb_cmd <= 3'h1;
    @(posedge CLOCK);
    ci.fill_active <= 1'b1;
    #1 chk(MEM_EN, 3'h4);
    @(posedge CLOCK);
    #1 chk({MEM_EN, CLK_EN.fill}, 32'hF);
    rd(OFF_STATUS);
    chk(rdv[ST_FREEZE_BIT], 1'b1);
    @(posedge CLOCK);
    slow           <= 1'b1;
    freeze_cmd     <= 1'b0;
    ci.fill_active <= 1'b0;
    inb_cmd        <= 3'h0;
    wait_stall(1'b0);
    chk(PIPE_STALL, 1'b0);
    @(posedge CLOCK);
    #1 chk({CLK_EN.core, MEM_EN}, 32'hF);
    // Reset in mid-run restores the power-up view and the control word
    wr(OFF_CTRL, 32'h0);
    @(posedge CLOCK);
    RESET <= 1'b1;
    @(posedge CLOCK);
    #1 chk({CLK_EN, BRANCH_EN, MEM_EN}, 16'hFFF8);
    chk({SLEEP_IND, PIPE_STALL, INTLEVEL}, 32'h0);
    @(posedge CLOCK);
    RESET <= 1'b0;
    rd(OFF_CTRL);
    chk(rdv, 32'h3);
    stop_test();
  end
endmodule
